// ===== hw/rx_port_status_regs.v
/*
 * Per-receive-port register bank: frequency-detect control and stability
 * tracking, scratch registers, sticky read-clear packet error flags and a
 * read-clear error packet tally. Register access is a byte-wide address,
 * write strobe and read strobe from the serial-bus target on core_clk; the
 * read strobe is one cycle per byte read. Packet error events arrive as
 * one-cycle pulses from the packet receiver on core_clk. The measured
 * frequency arrives from logic on core_clk in MHz.
 * Stability counts assume the clock period given in the defines; a port
 * select beyond the last port reaches no copy, so its writes are dropped.
 * Reserved flag bits read as zero.
 */
`timescale 1ns/1ps
`include "rx_port_status_defines.vh"

module rx_port_status_regs #(
  parameter NUM_PORTS = 2,
  parameter SEL_W = 1,
  parameter FREQ_W = 8,
  parameter STAB_C0 = `STAB_T0_NS / `CLK_PERIOD_NS,
  parameter STAB_C1 = `STAB_T1_NS / `CLK_PERIOD_NS,
  parameter STAB_C2 = `STAB_T2_NS / `CLK_PERIOD_NS,
  parameter STAB_C3 = `STAB_T3_NS / `CLK_PERIOD_NS
) (
  input wire core_clk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output wire reg_hit,
  input wire [NUM_PORTS-1:0] pkt_done,
  input wire [NUM_PORTS-1:0] pkt_length_err,
  input wire [NUM_PORTS-1:0] pkt_payload_checksum_flag,
  input wire [NUM_PORTS-1:0] pkt_multibit_err,
  input wire [NUM_PORTS-1:0] pkt_singlebit_err,
  input wire [NUM_PORTS*FREQ_W-1:0] measured_freq,
  output wire [NUM_PORTS-1:0] header_fix_en,
  output reg [NUM_PORTS*FREQ_W-1:0] held_freq,
  output reg [NUM_PORTS-1:0] freq_stable,
  output reg [NUM_PORTS-1:0] freq_too_low
);

  // ****************************************************************
  // Decoding
  // ****************************************************************
  function is_port_reg;
    input [7:0] a;
    begin
      is_port_reg = (a == `FREQ_CTL_ADDR) || (a == `SCRATCH_A_ADDR) ||
        (a == `SCRATCH_B_ADDR) || (a == `ERR_FLAGS_ADDR) ||
        (a == `ERR_TALLY_ADDR);
    end
  endfunction

  function is_clear_read;
    input rd;
    input [7:0] a;
    input [7:0] target;
    begin
      is_clear_read = rd && (a == target);
    end
  endfunction

  // ****************************************************************
  // Stability thresholds
  // ****************************************************************
  function [20:0] stab_count;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: stab_count = STAB_C0[20:0];
        2'h1: stab_count = STAB_C1[20:0];
        2'h2: stab_count = STAB_C2[20:0];
        default: stab_count = STAB_C3[20:0];
      endcase
    end
  endfunction

  // ****************************************************************
  // Port select
  // ****************************************************************
  reg [SEL_W-1:0] port_sel;
  assign reg_hit = is_port_reg(reg_addr) || (reg_addr == `PORT_SELECT_ADDR);

  always @(posedge core_clk) begin
    if (srst) begin
      port_sel <= {SEL_W{1'b0}};
    end else if (reg_wr && reg_addr == `PORT_SELECT_ADDR) begin
      port_sel <= reg_wdata[SEL_W-1:0];
    end
  end

  // ****************************************************************
  // Per-port storage
  // ****************************************************************
  reg [7:0] freq_ctl [0:NUM_PORTS-1];
  reg [7:0] scratch_a [0:NUM_PORTS-1];
  reg [7:0] scratch_b [0:NUM_PORTS-1];
  reg [3:0] err_flags [0:NUM_PORTS-1];
  reg [7:0] err_tally [0:NUM_PORTS-1];
  reg [20:0] stab_cnt [0:NUM_PORTS-1];

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
      wire sel_me = ({{(32-SEL_W){1'b0}}, port_sel} == p);
      wire wr_me = reg_wr && sel_me;
      wire rd_flags = sel_me &&
        is_clear_read(reg_rd, reg_addr, `ERR_FLAGS_ADDR);
      wire rd_tally = sel_me &&
        is_clear_read(reg_rd, reg_addr, `ERR_TALLY_ADDR);
      wire [3:0] new_err;
      wire any_err;
      wire [FREQ_W-1:0] meas = measured_freq[p*FREQ_W +: FREQ_W];
      wire [FREQ_W-1:0] held = held_freq[p*FREQ_W +: FREQ_W];
      wire [FREQ_W-1:0] diff = (meas > held) ? meas - held : held - meas;
      wire [FREQ_W-1:0] hyst =
        {{(FREQ_W-2){1'b0}}, freq_ctl[p][`HYST_HI:`HYST_LO]};
      wire [FREQ_W-1:0] lolim =
        {{(FREQ_W-4){1'b0}}, freq_ctl[p][`LOLIM_HI:`LOLIM_LO]};
      wire out_band = diff > hyst;
      wire [20:0] need = stab_count(freq_ctl[p][`STAB_HI:`STAB_LO]);

      // ****************************************************************
      // Packet error events
      // ****************************************************************
      assign new_err[`LENGTH_BIT] = pkt_done[p] & pkt_length_err[p];
      assign new_err[`CKSUM_BIT] = pkt_done[p] & pkt_payload_checksum_flag[p];
      assign new_err[`MULTI_BIT] = pkt_done[p] & pkt_multibit_err[p];
      assign new_err[`SINGLE_BIT] = pkt_done[p] & pkt_singlebit_err[p];
      assign any_err = |new_err;
      // Single-bit headers fixed; multi-bit left untouched
      assign header_fix_en[p] = pkt_singlebit_err[p] &
        ~pkt_multibit_err[p];

      // ****************************************************************
      // Register writes
      // ****************************************************************
      always @(posedge core_clk) begin
        if (srst) begin
          freq_ctl[p] <= `FREQ_CTL_RESET;
          scratch_a[p] <= `SCRATCH_A_RESET;
          scratch_b[p] <= `SCRATCH_B_RESET;
        end else if (wr_me) begin
          case (reg_addr)
            `FREQ_CTL_ADDR: freq_ctl[p] <= reg_wdata;
            `SCRATCH_A_ADDR: scratch_a[p] <= reg_wdata;
            `SCRATCH_B_ADDR: scratch_b[p] <= reg_wdata;
            default: freq_ctl[p] <= freq_ctl[p];
          endcase
        end
      end

      // ****************************************************************
      // Sticky error flags
      // ****************************************************************
      // Sticky flags; new events win over the read clear
      always @(posedge core_clk) begin
        if (srst) begin
          err_flags[p] <= `FLAGS_RESET;
        end else if (rd_flags) begin
          err_flags[p] <= new_err;
        end else begin
          err_flags[p] <= err_flags[p] | new_err;
        end
      end

      // ****************************************************************
      // Error packet tally
      // ****************************************************************
      always @(posedge core_clk) begin
        if (srst) begin
          err_tally[p] <= `TALLY_RESET;
        end else if (rd_tally) begin
          err_tally[p] <= {7'h00, any_err};
        end else if (any_err && err_tally[p] != `TALLY_MAX) begin
          err_tally[p] <= err_tally[p] + 8'h01;
        end
      end

      // ****************************************************************
      // Frequency detect
      // ****************************************************************
      // Frequency capture with hysteresis, then stability timing
      always @(posedge core_clk) begin
        if (srst) begin
          held_freq[p*FREQ_W +: FREQ_W] <= {FREQ_W{1'b0}};
          stab_cnt[p] <= 21'h000000;
          freq_stable[p] <= 1'b0;
          freq_too_low[p] <= 1'b1;
        end else begin
          if (out_band) begin
            held_freq[p*FREQ_W +: FREQ_W] <= meas;
            stab_cnt[p] <= 21'h000000;
            freq_stable[p] <= 1'b0;
          end else if (stab_cnt[p] >= need) begin
            freq_stable[p] <= 1'b1;
          end else begin
            stab_cnt[p] <= stab_cnt[p] + 21'h000001;
          end
          freq_too_low[p] <= held < lolim;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read data
  // ****************************************************************
  always @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `PORT_SELECT_ADDR: reg_rdata <= {{(8-SEL_W){1'b0}}, port_sel};
        `FREQ_CTL_ADDR: reg_rdata <= freq_ctl[port_sel];
        `SCRATCH_A_ADDR: reg_rdata <= scratch_a[port_sel];
        `SCRATCH_B_ADDR: reg_rdata <= scratch_b[port_sel];
        `ERR_FLAGS_ADDR: reg_rdata <= {4'h0, err_flags[port_sel]};
        `ERR_TALLY_ADDR: reg_rdata <= err_tally[port_sel];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // rx_port_status_regs

// ===== hw/rx_port_status_defines.vh
/*
 * Register offsets, field positions, reset values and timing figures for
 * the per-receive-port status and frequency-detect register slice.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef RX_PORT_STATUS_DEFINES_VH
`define RX_PORT_STATUS_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PORT_SELECT_ADDR 8'h4C
`define FREQ_CTL_ADDR 8'h77
`define SCRATCH_A_ADDR 8'h78
`define SCRATCH_B_ADDR 8'h79
`define ERR_FLAGS_ADDR 8'h7A
`define ERR_TALLY_ADDR 8'h7B

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define HYST_HI 7
`define HYST_LO 6
`define STAB_HI 5
`define STAB_LO 4
`define LOLIM_HI 3
`define LOLIM_LO 0
`define FREQ_CTL_RESET 8'hC5
`define SCRATCH_A_RESET 8'h00
`define SCRATCH_B_RESET 8'h01
`define FLAGS_RESET 4'h0
`define TALLY_RESET 8'h00
`define TALLY_MAX 8'hFF
`define LENGTH_BIT 3
`define CKSUM_BIT 2
`define MULTI_BIT 1
`define SINGLE_BIT 0

// ****************************************************************
// Stability times in nanoseconds, clock period in nanoseconds
// ****************************************************************
`define STAB_T0_NS 40000
`define STAB_T1_NS 80000
`define STAB_T2_NS 320000
`define STAB_T3_NS 1280000
`define CLK_PERIOD_NS 5

`endif

// ===== tb/rx_port_status_regs_properties.sv
/* Port checker for the receive-port register slice.
   Assumes a bind onto the top module and a one-bit port select. */
`timescale 1ns/1ps
module rx_port_status_checker #(parameter NUM_PORTS = 2, FREQ_W = 8) (
  input wire core_clk, srst, reg_wr, reg_rd, reg_hit,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire [NUM_PORTS-1:0] pkt_done, pkt_length_err,
  input wire [NUM_PORTS-1:0] pkt_multibit_err, pkt_singlebit_err,
  input wire [NUM_PORTS-1:0] header_fix_en, freq_stable,
  input wire [NUM_PORTS*FREQ_W-1:0] held_freq
);
  reg sel;
  always @(posedge core_clk)
    if (srst) sel <= 1'b0;
    else if (reg_wr && reg_addr == 8'h4C) sel <= reg_wdata[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence clr_rd(a);
    reg_rd && !reg_wr && reg_addr == a && pkt_done == '0;
  endsequence
  sequence hit_rd;
    reg_rd && !reg_wr && reg_addr == 8'h7A && pkt_done[sel] &&
      pkt_length_err[sel];
  endsequence
  a_reset_rdata: assert property (disable iff (1'b0)
    srst |=> !reg_rdata) else $error("read data not cleared by reset");
  a_hit_decode: assert property (reg_hit == (reg_addr == 8'h4C ||
    (reg_addr >= 8'h77 && reg_addr <= 8'h7B))) else $error("bad decode");
  a_unmapped_zero: assert property (reg_rd && !reg_hit |=> !reg_rdata)
    else $error("unmapped read not zero");
  a_flags_clear: assert property (clr_rd(8'h7A) ##1 clr_rd(8'h7A) |=>
    !reg_rdata) else $error("flags not cleared by read");
  a_tally_clear: assert property (clr_rd(8'h7B) ##1 clr_rd(8'h7B) |=>
    !reg_rdata) else $error("tally not cleared by read");
  a_clear_survive: assert property (hit_rd ##1 clr_rd(8'h7A) |=>
    reg_rdata[3]) else $error("event lost in clearing read");
  a_header_fix: assert property (header_fix_en ==
    (pkt_singlebit_err & ~pkt_multibit_err)) else $error("bad header fix");
  a_stable_restart: assert property (
    $changed(held_freq[FREQ_W-1:0]) |-> !freq_stable[0])
    else $error("stable kept over new capture");
endmodule // rx_port_status_checker
bind rx_port_status_regs rx_port_status_checker #(.NUM_PORTS(NUM_PORTS),
  .FREQ_W(FREQ_W)) chk_i (.core_clk(core_clk), .srst(srst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_hit(reg_hit), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pkt_done(pkt_done),
  .pkt_length_err(pkt_length_err), .pkt_multibit_err(pkt_multibit_err),
  .pkt_singlebit_err(pkt_singlebit_err), .header_fix_en(header_fix_en),
  .freq_stable(freq_stable), .held_freq(held_freq));

// ===== tb/serializer_pkt_model.sv
/* Remote packet source: a one-cycle packet end on one port with error
   levels. Assumes commands change just after a falling edge. */
`timescale 1ns/1ps
module serializer_pkt_model (
  input wire core_clk,
  input wire go,
  input wire port,
  input wire [3:0] errs,
  output wire [1:0] pkt_done,
  output wire [1:0] length_err,
  output wire [1:0] payload_checksum_flag,
  output wire [1:0] multi_err,
  output wire [1:0] single_err
);
  reg [3:0] churn = 4'hA;
  wire [3:0] lvl = go ? errs : churn;
  // Levels churn between packets
  always @(posedge core_clk) churn <= ~churn;
  assign pkt_done = go ? (port ? 2'b10 : 2'b01) : 2'b00;
  assign length_err = {2{lvl[3]}};
  assign payload_checksum_flag = {2{lvl[2]}};
  assign multi_err = {2{lvl[1]}};
  assign single_err = {2{lvl[0]}};
endmodule // serializer_pkt_model

// ===== tb/tb_rx_port_status_regs.sv
/* Bench for the register slice with a packet source model.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/1ps
module tb_rx_port_status_regs;
  reg core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, go = 0, port = 0;
  reg [7:0] reg_addr = 0, reg_wdata = 0, ra, rb, q[$];
  reg [3:0] errs = 0, acc = 0;
  reg [15:0] mf = 0;
  reg [31:0] rs = 32'hFD832BAB;
  reg rd_d = 0;
  wire [7:0] rdata;
  wire [1:0] pd, le, ce, me, se, stab, low;
  wire [15:0] held;
  integer bad_count = 0, cmp_count = 0, cyc = 0, i;
  always #2.5 core_clk = ~core_clk;
  rx_port_status_regs #(.STAB_C0(4), .STAB_C1(8), .STAB_C2(16), .STAB_C3(32))
    rx_port_status_regs_i (.core_clk(core_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata), .reg_hit(), .pkt_done(pd),
    .pkt_length_err(le), .pkt_payload_checksum_flag(ce), .pkt_multibit_err(me),
    .pkt_singlebit_err(se), .measured_freq(mf), .header_fix_en(),
    .held_freq(held), .freq_stable(stab), .freq_too_low(low));
  serializer_pkt_model serializer_pkt_model_i (.core_clk(core_clk), .go(go),
    .port(port), .errs(errs), .pkt_done(pd), .length_err(le), .payload_checksum_flag(ce),
    .multi_err(me), .single_err(se));
  task check(input [7:0] g, input [7:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task check_pin(input [7:0] g, input [7:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: pin %h expected %h", $time, g, e);
    end
  endtask
  function [31:0] xorshift(input [31:0] s);
    reg [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xorshift = t ^ (t << 5);
  endfunction
  task op(input w, input r, input [7:0] a, input [7:0] d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, r, a, d};
    @(negedge core_clk);
  endtask
  task rd(input [7:0] a, input [7:0] e);
    q.push_back(e);
    op(0, 1, a, 0);
  endtask
  task idle(input integer n);
    op(0, 0, reg_addr, 0);
    repeat (n - 1) @(negedge core_clk);
  endtask
  task send(input [3:0] e);
    {go, errs} = {1'b1, e};
    idle(1);
    go = 0;
    idle(1);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk) {rd_d, cyc} <= {reg_rd, cyc + 1};
  always @(negedge core_clk) begin
    if (rd_d) check(rdata, q.pop_front());
    if (cyc > 20000) begin
      bad_count++;
      final_report;
    end
  end
  initial begin
    repeat (20) @(negedge core_clk);
    srst = 0;
    rd(8'h77, 8'hC5);
    rd(8'h79, 8'h01);
    rd(8'h7B, 8'h00);
    rd(8'h7A, 8'h00);
    rd(8'h50, 8'h00);
    idle(1);
    check_pin(low, 2'b11);
    $display("reset test done");
    rs = xorshift(rs);
    {ra, rb} = rs[15:0];
    op(1, 0, 8'h78, ra);
    op(1, 0, 8'h79, rb);
    op(1, 0, 8'h4C, 8'h01);
    op(1, 0, 8'h78, ~ra);
    op(1, 0, 8'h7A, 8'hFF);
    rd(8'h78, ~ra);
    rd(8'h79, 8'h01);
    rd(8'h7A, 8'h00);
    op(1, 0, 8'h4C, 8'h00);
    rd(8'h78, ra);
    rd(8'h79, rb);
    idle(1);
    $display("routing test done");
    for (i = 0; i < 4; i++) begin
      send(4'h1 << i);
      rd(8'h7A, 8'h01 << i);
      rd(8'h7A, 8'h00);
      rd(8'h7B, 8'h01);
    end
    port = 1;
    send(4'hF);
    port = 0;
    send(4'h1);
    send(4'h4);
    rd(8'h7A, 8'h05);
    rd(8'h7B, 8'h02);
    op(1, 0, 8'h4C, 8'h01);
    rd(8'h7A, 8'h0F);
    rd(8'h7B, 8'h01);
    op(1, 0, 8'h4C, 8'h00);
    for (i = 0; i < 300; i++) begin
      rs = xorshift(rs);
      acc = acc | rs[3:0] | 4'h1;
      send(rs[3:0] | 4'h1);
    end
    send(4'h0);
    rd(8'h7B, 8'hFF);
    {go, errs} = 5'h18;
    rd(8'h7A, {4'h0, acc});
    go = 0;
    rd(8'h7A, 8'h08);
    rd(8'h7B, 8'h01);
    rd(8'h7B, 8'h00);
    idle(1);
    $display("packet test done");
    for (i = 0; i < 4; i++) begin
      op(1, 0, 8'h77, {2'b11, i[1:0], 4'h5});
      mf[7:0] = 8'h14 + 8'h08 * i;
      idle(4 << i);
      check_pin(stab[0], 8'h00);
      idle(3);
      check_pin(stab[0], 8'h01);
    end
    mf[7:0] = 8'h2E;
    idle(3);
    check_pin(held[7:0], 8'h2C);
    mf[7:0] = 8'h31;
    idle(3);
    check_pin(held[7:0], 8'h31);
    mf[7:0] = 8'h34;
    idle(3);
    check_pin(held[7:0], 8'h31);
    check_pin(low[0], 8'h00);
    op(1, 0, 8'h77, 8'hCF);
    mf[7:0] = 8'h0A;
    idle(3);
    check_pin(low[0], 8'h01);
    $display("frequency test done");
    final_report;
  end
endmodule // tb_rx_port_status_regs
